// *** src/dsr_pkg.sv ***
package dsr_pkg;
   // Access levels
   localparam logic [1:0] ACC_BASIC = 2'h0;
   localparam logic [1:0] ACC_EXT = 2'h1;
   localparam logic [1:0] ACC_LOCK = 2'h2;
   localparam logic [6:0] PAR_FIRST = 7'h01;
   localparam logic [6:0] PAR_BASIC_LAST = 7'h0A;
   localparam logic [6:0] PAR_EXT_LAST = 7'h50;
   // Analog input modes
   localparam logic [3:0] AIN_0_20 = 4'h0;
   localparam logic [3:0] AIN_20_0 = 4'h1;
   localparam logic [3:0] AIN_4_20_LOSS = 4'h2;
   localparam logic [3:0] AIN_20_4_LOSS = 4'h3;
   localparam logic [3:0] AIN_4_20 = 4'h4;
   localparam logic [3:0] AIN_20_4 = 4'h5;
   localparam logic [3:0] AIN_VOLT = 4'h6;
   localparam logic [3:0] AIN_DIGITAL = 4'h7;
   localparam logic [3:0] AIN_THERM = 4'h8;
   // Input sample: 12 bit, full scale 20 mA; 4 mA is one fifth, loss below 3 mA
   localparam logic [11:0] AIN_FULL = 12'hFFF;
   localparam logic [11:0] AIN_4MA = 12'h333;
   localparam logic [11:0] AIN_LOSS_LVL = 12'h266;
   localparam logic [11:0] AIN_DIG_LVL = 12'h800;
   // Power-up keypad reference modes
   localparam logic [1:0] PU_CLEAR = 2'h0;
   localparam logic [1:0] PU_RESTORE = 2'h1;
   localparam logic [1:0] PU_PRESET = 2'h2;
   // Reference format: signed 16 bit, 100.0% = 1000
   localparam logic signed [15:0] REF_FULL = 16'sh03E8;
   localparam logic signed [15:0] REF_ZERO = 16'sh0000;
   // Clock and slew timing
   localparam int CLK_MHZ = 250;
   localparam int POT_TICK_US = 100;
   localparam int POT_TICK_CYC = POT_TICK_US * CLK_MHZ;
   localparam logic [15:0] RATE_RST = 16'h0001;
   typedef enum logic [1:0] {
      RUN_IDLE = 2'b00,
      RUN_ON = 2'b01,
      RUN_BLOCKED = 2'b10
   } dsr_run_t;
endpackage

// *** src/dsr_selector.sv ***
// Contract
// [R1] Level 0: keypad reaches parameters 01-10 only
// [R2] Level 1: keypad reaches parameters 01-80
// [R3] Level 2: store or re-enable security lock
// [R4] Mode field selects analog input range
// [R5] Signal loss flagged only in modes 2, 3
// [R6] Second input mode 8 monitors thermistor
// [R7] Power-up keypad reference: clear/restore/preset
// [R8] Pot reset forces motorised reference zero
// [R9] Pot modes 0,2 clear; 1,3 restore
// [R10] Modes 2,3 gate up/down on drive active
// [R11] Polarity selects 0..100% or -100..+100% clamp
// [R12] Fixed slew rate set by pot-rate time
// [R13] Pot 100% maps to max clamp, scaled
// [R14] PID gains apply on enable reclose
// [R15] PID output clamped between upper, lower limits
// [R16] PID scaled, added, fit to destination range
// [R17] Forward key honoured only when enabled
// [R18] Enabled stop key acts under terminal control
// [R19] After keypad stop, terminal run must recycle
// [R20] Reverse key honoured only when enabled
// [R21] Eight-preset mode selects by three inputs
// [R22] Pot, keypad references kept in retained storage
`timescale 1ns/1ps
`default_nettype none
module dsr_selector (
   input wire logic mclk_i, // 250 MHz clock
   input wire logic sys_rst_i, // Synchronous reset, high
   input wire logic power_up_i, // Pulse: power has just returned
   input wire logic [1:0] access_level_i, // Keypad access level
   input wire logic [6:0] key_param_i, // Parameter number addressed by keypad
   input wire logic [13:0] sec_code_i, // Security code entered
   input wire logic sec_store_i, // Pulse: store security code
   input wire logic [3:0] ain1_mode_i, // First analog input mode
   input wire logic [3:0] ain2_mode_i, // Second analog input mode
   input wire logic [11:0] ain1_raw_i, // First analog sample (async)
   input wire logic [11:0] ain2_raw_i, // Second analog sample (async)
   input wire logic keypad_cfg_i, // Keypad configuration active
   input wire logic pot_cfg_i, // Motorised pot configuration active
   input wire logic pid_cfg_i, // PID configuration active
   input wire logic preset8_cfg_i, // Eight-preset configuration active
   input wire logic [1:0] pu_mode_i, // Power-up keypad reference mode
   input wire logic signed [15:0] pu_preset_i, // Power-up preset reference
   input wire logic signed [15:0] keypad_ref_i, // Keypad reference being set
   input wire logic pot_clear_i, // Pot reset parameter at 1
   input wire logic [1:0] pot_mode_i, // Motorised pot mode
   input wire logic pot_two_sided_i, // Pot polarity select
   input wire logic [15:0] pot_rate_i, // Ticks per 0.1% step
   input wire logic [7:0] pot_scale_i, // Pot scale, 128 = 1.0
   input wire logic signed [15:0] max_clamp_i, // Maximum reference clamp
   input wire logic pot_up_i, // Up input (pin)
   input wire logic pot_down_i, // Down input (pin)
   input wire logic drive_active_i, // Drive output active
   input wire logic [2:0] preset_sel_i, // Preset select inputs (pins)
   input wire logic [127:0] preset_refs_i, // Eight presets, 16 bit each
   input wire logic pid_enable_input_i, // PID enable terminal (pin)
   input wire logic [7:0] pid_kp_i, // PID proportional gain
   input wire logic [7:0] pid_ki_i, // PID integral gain
   input wire logic [7:0] pid_kd_i, // PID derivative gain
   input wire logic signed [15:0] pid_raw_i, // PID regulator output
   input wire logic signed [15:0] pid_hi_i, // PID upper limit
   input wire logic signed [15:0] pid_lo_i, // PID lower limit
   input wire logic [7:0] pid_scale_i, // PID output scale, 128 = 1.0
   input wire logic signed [15:0] main_ref_i, // Main reference
   input wire logic signed [15:0] dest_max_i, // Destination range maximum
   input wire logic key_fwd_i, // Forward key press
   input wire logic key_rev_i, // Reverse key press
   input wire logic key_stop_i, // Stop key press
   input wire logic fwd_en_i, // Forward key enable
   input wire logic rev_en_i, // Reverse key enable
   input wire logic stop_en_i, // Stop key enable
   input wire logic term_run_i, // Terminal run command (pin)
   output logic access_ok_o, // Keypad access granted
   output logic lock_armed_o, // Security lock armed
   output logic [13:0] lock_code_o, // Stored security code
   output logic ain1_loss_o, // First input signal loss
   output logic ain2_loss_o, // Second input signal loss
   output logic ain1_digital_o, // First input as digital
   output logic ain2_digital_o, // Second input as digital
   output logic therm_trip_o, // Thermistor over-temperature
   output logic [11:0] ain1_level_o, // First input normalised level
   output logic [11:0] ain2_level_o, // Second input normalised level
   output logic signed [15:0] keypad_ref_o, // Active keypad reference
   output logic signed [15:0] pot_level_o, // Pot reference before scaling
   output logic signed [15:0] pot_ref_o, // Scaled pot reference
   output logic signed [15:0] preset_ref_o, // Selected preset reference
   output logic [23:0] pid_gains_o, // Applied PID gains kd,ki,kp
   output logic signed [15:0] pid_ref_o, // Combined PID reference
   output logic run_o, // Drive run request
   output logic reverse_o // Direction reverse
);
   // Pin synchronisers
   logic [1:0] up_s_r, dn_s_r, pid_s_r, run_s_r;
   logic [2:0] psel_a_r, psel_b_r;
   logic [11:0] a1_a_r, a1_b_r, a2_a_r, a2_b_r;
   always_ff @(posedge mclk_i) begin
      up_s_r <= {up_s_r[0], pot_up_i};
      dn_s_r <= {dn_s_r[0], pot_down_i};
      pid_s_r <= {pid_s_r[0], pid_enable_input_i};
      run_s_r <= {run_s_r[0], term_run_i};
      psel_a_r <= preset_sel_i;
      psel_b_r <= psel_a_r;
      a1_a_r <= ain1_raw_i;
      a1_b_r <= a1_a_r;
      a2_a_r <= ain2_raw_i;
      a2_b_r <= a2_a_r;
   end

   // Keypad access decode
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         access_ok_o <= 1'b0;
      end else begin
         case (access_level_i)
            dsr_pkg::ACC_BASIC: access_ok_o <= key_param_i >= dsr_pkg::PAR_FIRST &&
               key_param_i <= dsr_pkg::PAR_BASIC_LAST; // see [R1]
            dsr_pkg::ACC_EXT: access_ok_o <= key_param_i >= dsr_pkg::PAR_FIRST &&
               key_param_i <= dsr_pkg::PAR_EXT_LAST; // see [R2]
            default: access_ok_o <= 1'b0;
         endcase
      end
   end

   // Lock state; only the lock level lets a code be stored or the lock re-armed
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         lock_armed_o <= 1'b0;
         lock_code_o <= 14'h0000;
      end else if (access_level_i == dsr_pkg::ACC_LOCK) begin
         lock_armed_o <= 1'b1; // see [R3]
         if (sec_store_i) begin
            lock_code_o <= sec_code_i; // see [R3]
         end
      end
   end

   // Analog range conversion, loss detection and special uses
   function automatic logic [11:0] ain_norm(input logic [3:0] m, input logic [11:0] v);
      logic [12:0] span;
      span = 13'(v) - 13'(dsr_pkg::AIN_4MA);
      if (v < dsr_pkg::AIN_4MA) begin
         span = 13'h0000;
      end
      case (m)
         dsr_pkg::AIN_0_20, dsr_pkg::AIN_VOLT: ain_norm = v; // see [R4]
         dsr_pkg::AIN_20_0: ain_norm = dsr_pkg::AIN_FULL - v; // see [R4]
         dsr_pkg::AIN_4_20_LOSS, dsr_pkg::AIN_4_20: ain_norm = 12'((15'(span) * 15'h0005) >> 2); // see [R4]
         dsr_pkg::AIN_20_4_LOSS, dsr_pkg::AIN_20_4:
            ain_norm = dsr_pkg::AIN_FULL - 12'((15'(span) * 15'h0005) >> 2); // see [R4]
         default: ain_norm = 12'h000;
      endcase
   endfunction

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ain1_level_o <= 12'h000;
         ain2_level_o <= 12'h000;
         ain1_loss_o <= 1'b0;
         ain2_loss_o <= 1'b0;
         ain1_digital_o <= 1'b0;
         ain2_digital_o <= 1'b0;
         therm_trip_o <= 1'b0;
      end else begin
         ain1_level_o <= ain_norm(ain1_mode_i, a1_b_r);
         ain2_level_o <= ain_norm(ain2_mode_i, a2_b_r);
         ain1_loss_o <= (ain1_mode_i == dsr_pkg::AIN_4_20_LOSS || ain1_mode_i == dsr_pkg::AIN_20_4_LOSS) &&
            a1_b_r < dsr_pkg::AIN_LOSS_LVL; // see [R5]
         ain2_loss_o <= (ain2_mode_i == dsr_pkg::AIN_4_20_LOSS || ain2_mode_i == dsr_pkg::AIN_20_4_LOSS) &&
            a2_b_r < dsr_pkg::AIN_LOSS_LVL; // see [R5]
         ain1_digital_o <= ain1_mode_i == dsr_pkg::AIN_DIGITAL && a1_b_r >= dsr_pkg::AIN_DIG_LVL; // see [R4]
         ain2_digital_o <= ain2_mode_i == dsr_pkg::AIN_DIGITAL && a2_b_r >= dsr_pkg::AIN_DIG_LVL;
         // High sensor resistance reads as a high level and trips
         therm_trip_o <= ain2_mode_i == dsr_pkg::AIN_THERM && a2_b_r >= dsr_pkg::AIN_DIG_LVL; // see [R6]
      end
   end

   // Retained storage: no reset of its own, but it copies the live references, so reset clears it one cycle later
   logic signed [15:0] keep_key_r, keep_pot_r;
   always_ff @(posedge mclk_i) begin
      keep_key_r <= keypad_ref_o; // see [R22]
      keep_pot_r <= pot_level_o; // see [R22]
   end

   // Keypad reference with power-up policy
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         keypad_ref_o <= dsr_pkg::REF_ZERO;
      end else if (power_up_i && keypad_cfg_i) begin
         case (pu_mode_i)
            dsr_pkg::PU_CLEAR: keypad_ref_o <= dsr_pkg::REF_ZERO; // see [R7]
            dsr_pkg::PU_RESTORE: keypad_ref_o <= keep_key_r; // see [R7]
            dsr_pkg::PU_PRESET: keypad_ref_o <= pu_preset_i; // see [R7]
            default: keypad_ref_o <= dsr_pkg::REF_ZERO;
         endcase
      end else begin
         keypad_ref_o <= keypad_ref_i;
      end
   end

   // Slew tick: one 0.1% step each pot_rate ticks, so 0 to 100% takes rate*1000 ticks
   logic [14:0] tick_cnt_r;
   logic [15:0] step_cnt_r;
   logic tick_r;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tick_cnt_r <= 15'h0000;
         tick_r <= 1'b0;
      end else begin
         tick_r <= tick_cnt_r == 15'(dsr_pkg::POT_TICK_CYC - 1);
         tick_cnt_r <= (tick_cnt_r == 15'(dsr_pkg::POT_TICK_CYC - 1)) ? 15'h0000 : tick_cnt_r + 15'h0001;
      end
   end

   logic step_r;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         step_cnt_r <= 16'h0000;
         step_r <= 1'b0;
      end else begin
         step_r <= 1'b0;
         if (tick_r) begin
            if (step_cnt_r + 16'h0001 >= (pot_rate_i == 16'h0000 ? dsr_pkg::RATE_RST : pot_rate_i)) begin
               step_cnt_r <= 16'h0000;
               step_r <= 1'b1; // see [R12]
            end else begin
               step_cnt_r <= step_cnt_r + 16'h0001;
            end
         end
      end
   end

   // Motorised pot level
   logic pot_gate;
   logic signed [15:0] pot_min;
   assign pot_gate = !pot_mode_i[1] || drive_active_i; // see [R10]
   assign pot_min = pot_two_sided_i ? -dsr_pkg::REF_FULL : dsr_pkg::REF_ZERO; // see [R11]
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pot_level_o <= dsr_pkg::REF_ZERO;
      end else if (pot_cfg_i && pot_clear_i) begin
         pot_level_o <= dsr_pkg::REF_ZERO; // see [R8]
      end else if (power_up_i) begin
         pot_level_o <= pot_mode_i[0] ? keep_pot_r : dsr_pkg::REF_ZERO; // see [R9]
      end else if (pot_level_o < pot_min) begin
         pot_level_o <= pot_min; // see [R11]
      end else if (pot_cfg_i && pot_gate && step_r) begin
         if (up_s_r[1] && !dn_s_r[1] && pot_level_o < dsr_pkg::REF_FULL) begin
            pot_level_o <= pot_level_o + 16'sh0001; // see [R12]
         end else if (dn_s_r[1] && !up_s_r[1] && pot_level_o > pot_min) begin
            pot_level_o <= pot_level_o - 16'sh0001; // see [R11]
         end
      end
   end

   // Pot scaling: level/1000 of max clamp, times scale/128
   logic signed [39:0] pot_prod;
   assign pot_prod = 40'(pot_level_o) * 40'(max_clamp_i) * 40'($signed({1'b0, pot_scale_i}));
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pot_ref_o <= dsr_pkg::REF_ZERO;
      end else begin
         pot_ref_o <= 16'((pot_prod / 40'sd1000) >>> 7); // see [R13]
      end
   end

   // Eight-preset selection from synchronised inputs
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         preset_ref_o <= dsr_pkg::REF_ZERO;
      end else if (preset8_cfg_i) begin
         preset_ref_o <= preset_refs_i[psel_b_r * 16 +: 16]; // see [R21]
      end
   end

   // PID gains latch on a closing edge of the enable terminal
   logic pid_en_d_r;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pid_en_d_r <= 1'b0;
         pid_gains_o <= 24'h000000;
      end else begin
         pid_en_d_r <= pid_s_r[1];
         if (pid_cfg_i && pid_s_r[1] && !pid_en_d_r) begin
            pid_gains_o <= {pid_kd_i, pid_ki_i, pid_kp_i}; // see [R14]
         end
      end
   end

   // PID clamp, scale, sum and fit to destination range
   logic signed [15:0] pid_clamped;
   logic signed [26:0] pid_sum;
   assign pid_clamped = (pid_raw_i > pid_hi_i) ? pid_hi_i : (pid_raw_i < pid_lo_i) ? pid_lo_i : pid_raw_i; // see [R15]
   assign pid_sum = ((27'(pid_clamped) * 27'($signed({1'b0, pid_scale_i}))) >>> 7) + 27'(main_ref_i); // see [R16]
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pid_ref_o <= dsr_pkg::REF_ZERO;
      end else if (pid_sum > 27'(dest_max_i)) begin
         pid_ref_o <= dest_max_i; // see [R16]
      end else if (pid_sum < -27'(dest_max_i)) begin
         pid_ref_o <= -dest_max_i; // see [R16]
      end else begin
         pid_ref_o <= 16'(pid_sum);
      end
   end

   // Run control: keypad keys and terminal run with restart interlock
   dsr_pkg::dsr_run_t run_st_r;
   logic stop_hit, fwd_hit, rev_hit;
   assign stop_hit = stop_en_i && key_stop_i; // see [R18]
   assign fwd_hit = keypad_cfg_i && fwd_en_i && key_fwd_i; // see [R17]
   assign rev_hit = keypad_cfg_i && rev_en_i && key_rev_i; // see [R20]
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         run_st_r <= dsr_pkg::RUN_IDLE;
         run_o <= 1'b0;
         reverse_o <= 1'b0;
      end else begin
         case (run_st_r)
            dsr_pkg::RUN_IDLE: begin
               if (!stop_hit && (fwd_hit || rev_hit || run_s_r[1])) begin
                  run_st_r <= dsr_pkg::RUN_ON;
                  run_o <= 1'b1;
                  reverse_o <= rev_hit && !fwd_hit; // see [R20]
               end
            end
            dsr_pkg::RUN_ON: begin
               if (stop_hit) begin
                  // A held terminal run would otherwise restart at once
                  run_st_r <= run_s_r[1] ? dsr_pkg::RUN_BLOCKED : dsr_pkg::RUN_IDLE; // see [R19]
                  run_o <= 1'b0;
               end else if (!keypad_cfg_i && !run_s_r[1]) begin
                  run_st_r <= dsr_pkg::RUN_IDLE;
                  run_o <= 1'b0;
               end else if (rev_hit != fwd_hit) begin
                  reverse_o <= rev_hit; // see [R20]
               end
            end
            dsr_pkg::RUN_BLOCKED: begin
               if (!run_s_r[1]) begin
                  run_st_r <= dsr_pkg::RUN_IDLE; // see [R19]
               end
            end
            default: begin
               run_st_r <= dsr_pkg::RUN_IDLE;
               run_o <= 1'b0;
            end
         endcase
      end
   end

   a_basic_access: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [R1]
      access_level_i == dsr_pkg::ACC_BASIC && key_param_i == 7'h0B |=> !access_ok_o)
      else $error("basic level granted parameter 11");
   a_ext_access: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [R2]
      access_level_i == dsr_pkg::ACC_EXT && key_param_i == 7'h50 |=> access_ok_o)
      else $error("extended level denied parameter 80");
   a_loss_modes: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [R5]
      ain1_mode_i == dsr_pkg::AIN_4_20 |=> !ain1_loss_o)
      else $error("loss flagged in mode without detection");
   a_pot_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [R8]
      pot_cfg_i && pot_clear_i |=> pot_level_o == 16'sh0000)
      else $error("pot not cleared");
   a_pot_bounds: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [R11]
      ##1 $stable(pot_two_sided_i) && !pot_two_sided_i && $past(pot_level_o) >= 16'sh0000 |->
      pot_level_o >= 16'sh0000 && pot_level_o <= dsr_pkg::REF_FULL)
      else $error("pot left one-sided range");
   a_pot_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [R10]
      pot_mode_i[1] && !drive_active_i && !pot_clear_i && !power_up_i && pot_level_o >= pot_min |=>
      $stable(pot_level_o))
      else $error("pot moved while drive inactive");
   a_gain_latch: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [R14]
      !(pid_s_r[1] && !pid_en_d_r) |=> $stable(pid_gains_o))
      else $error("gains changed without enable reclose");
   a_stop_block: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [R19]
      run_st_r == dsr_pkg::RUN_BLOCKED && run_s_r[1] |=> !run_o)
      else $error("restart while run still held");
   a_fwd_disabled: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [R17]
      run_st_r == dsr_pkg::RUN_IDLE && !fwd_en_i && !rev_hit && !run_s_r[1] |=> !run_o)
      else $error("disabled forward key started drive");
endmodule
`default_nettype wire

// *** verif/dsr_field_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Terminal block and pins, updated on the edge like a flop so bench and pins never race
module dsr_field_model (
   input wire logic mclk_i, // Clock
   input wire logic [7:0] cmd_i, // Wanted pin levels
   output logic term_run_o, // Terminal run
   output logic pot_up_o, // Up pin
   output logic pot_down_o, // Down pin
   output logic pid_en_o, // PID enable pin
   output logic [2:0] preset_sel_o // Preset select pins
);
   // Pins start open so the drive sees no command at power-on
   initial {preset_sel_o, pid_en_o, pot_down_o, pot_up_o, term_run_o} = 7'h00;
   // The bench orders run recycling and enable reclosing; pins follow on the next edge
   always @(posedge mclk_i) begin
      {preset_sel_o, pid_en_o, pot_down_o, pot_up_o, term_run_o} <= cmd_i[6:0];
   end
endmodule
`default_nettype wire

// *** verif/tb_drive_speed_reference_selector.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_drive_speed_reference_selector;
   typedef struct {int ch; logic [23:0] v;} dsr_note_t;
   logic mclk_i = 1'b0, sys_rst_i = 1'b1, power_up_i = 1'b0, sec_store_i = 1'b0, pot_clear_i = 1'b0;
   logic [1:0] access_level_i = 2'h0, pu_mode_i = 2'h0, pot_mode_i = 2'h0;
   logic [6:0] key_param_i = 7'h01;
   logic [13:0] sec_code_i = 14'h0000;
   logic [3:0] ain1_mode_i = 4'h0, ain2_mode_i = 4'h0;
   logic [11:0] ain1_raw_i = 12'h000, ain2_raw_i = 12'h000;
   logic keypad_cfg_i = 1'b0, pot_cfg_i = 1'b0, pid_cfg_i = 1'b0, preset8_cfg_i = 1'b0, pot_two_sided_i = 1'b0;
   logic drive_active_i = 1'b0, key_fwd_i = 1'b0, key_rev_i = 1'b0, key_stop_i = 1'b0;
   logic fwd_en_i = 1'b0, rev_en_i = 1'b0, stop_en_i = 1'b0;
   logic [15:0] pot_rate_i = 16'h0001;
   logic [7:0] pot_scale_i = 8'h80, pid_kp_i = 8'h00, pid_ki_i = 8'h00, pid_kd_i = 8'h00, pid_scale_i = 8'h80;
   logic signed [15:0] pu_preset_i = 16'sh0000, keypad_ref_i = 16'sh0000, max_clamp_i = 16'sh03E8;
   logic signed [15:0] pid_raw_i = 16'sh0000, pid_hi_i = 16'sh012C, pid_lo_i = 16'shFF38;
   logic signed [15:0] main_ref_i = 16'sh0000, dest_max_i = 16'sh03E8;
   logic [127:0] preset_refs_i = 128'h0;
   logic [7:0] cmd = 8'h00;
   wire logic term_run_i, pot_up_i, pot_down_i, pid_enable_input_i;
   wire logic [2:0] preset_sel_i;
   logic access_ok_o, lock_armed_o, ain1_loss_o, ain2_loss_o, ain1_digital_o, ain2_digital_o, therm_trip_o;
   logic run_o, reverse_o;
   logic [13:0] lock_code_o;
   logic [11:0] ain1_level_o, ain2_level_o;
   logic signed [15:0] keypad_ref_o, pot_level_o, pot_ref_o, preset_ref_o, pid_ref_o;
   logic [23:0] pid_gains_o;
   int bad_count = 0, comparisons = 0;
   dsr_note_t q[$];
   event look;

   dsr_selector i_dut (.*);
   dsr_field_model i_field (.mclk_i(mclk_i), .cmd_i(cmd), .term_run_o(term_run_i), .pot_up_o(pot_up_i),
      .pot_down_o(pot_down_i), .pid_en_o(pid_enable_input_i), .preset_sel_o(preset_sel_i));

   // 250 MHz clock
   initial forever #2 mclk_i = ~mclk_i;

   // Output seen by each note channel
   function automatic logic [23:0] obs(input int ch);
      case (ch)
         0: obs = {23'h0, access_ok_o};
         1: obs = {23'h0, lock_armed_o};
         2: obs = {10'h0, lock_code_o};
         3: obs = {20'h0, ain1_digital_o, ain1_loss_o, ain2_loss_o, ain2_digital_o};
         4: obs = {23'h0, therm_trip_o};
         5: obs = {ain1_level_o, ain2_level_o};
         6: obs = {8'h0, pot_level_o};
         7: obs = {8'h0, pot_ref_o};
         8: obs = {8'h0, preset_ref_o};
         9: obs = pid_gains_o;
         10: obs = {8'h0, pid_ref_o};
         11: obs = {22'h0, reverse_o, run_o};
         12: obs = {23'h0, run_o};
         13: obs = {8'h0, keypad_ref_o};
         default: obs = 24'hFFFFFF;
      endcase
   endfunction

   task automatic end_sim;
      if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Settle n edges, then land just after the last one
   task automatic step(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task automatic note(input int ch, input logic [23:0] v);
      q.push_back('{ch, v});
      -> look;
   endtask

   // Expected level per mode: the 4 mA floor maps to zero, the rest stretched to full scale
   function automatic logic [11:0] lvl(input int m, input logic [11:0] v);
      logic [11:0] s;
      s = v < dsr_pkg::AIN_4MA ? 12'h000 : 12'((int'(v) - int'(dsr_pkg::AIN_4MA)) * 5 / 4);
      case (m)
         0, 6: lvl = v;
         1: lvl = dsr_pkg::AIN_FULL - v;
         2, 4: lvl = s;
         3, 5: lvl = dsr_pkg::AIN_FULL - s;
         default: lvl = 12'h000;
      endcase
   endfunction

   // Keypad input is moved away at the power edge so a restore cannot pass by following it
   task automatic pulse_power(input logic [1:0] pu, input logic [15:0] kx);
      pu_mode_i = pu;
      keypad_ref_i = 16'sh0000;
      power_up_i = 1'b1;
      step(1);
      note(13, {8'h0, kx});
      power_up_i = 1'b0;
      keypad_ref_i = 16'sh0123;
      step(3);
   endtask

   // Drains every note of the time step, since several may share one wake-up
   always @(look) begin
      while (q.size() > 0) begin
         comparisons++;
         if (obs(q[0].ch) !== q[0].v) begin
            bad_count++;
            $display("MISMATCH %0t channel %0d got %h expected %h", $time, q[0].ch, obs(q[0].ch), q[0].v);
         end
         void'(q.pop_front());
      end
   end

   // A hang ends the run as a failure
   initial begin
      #360000;
      bad_count++;
      end_sim();
   end

   initial begin
      logic [6:0] prm [5];
      logic [11:0] raw [2];
      logic signed [15:0] rw [3], mr [3], ex [3];
      logic [23:0] g;
      int i;
      prm = '{7'h01, 7'h0A, 7'h0B, 7'h50, 7'h51};
      raw = '{12'h100, 12'h900};
      rw = '{16'sh01F4, 16'shFD44, 16'sh0032};
      mr = '{16'sh0064, 16'sh0064, 16'sh03DE};
      ex = '{16'sh0190, 16'shFF9C, 16'sh03E8};
      void'($urandom(19997));
      repeat (6) @(posedge mclk_i);
      #1 sys_rst_i = 1'b0;
      // Access window edges at both levels, then arming the lock
      for (int l = 0; l < 2; l++) begin
         foreach (prm[k]) begin
            access_level_i = l[1:0];
            key_param_i = prm[k];
            step(2);
            note(0, (prm[k] <= (l == 0 ? 7'h0A : 7'h50)));
         end
      end
      access_level_i = 2'h2;
      sec_code_i = 14'($urandom);
      sec_store_i = 1'b1;
      step(1);
      sec_store_i = 1'b0;
      step(2);
      note(1, 24'h1);
      note(2, {10'h0, sec_code_i});
      // Every input mode against a low and a high sample
      for (int m = 0; m < 9; m++) begin
         foreach (raw[k]) begin
            ain2_mode_i = m[3:0];
            ain1_mode_i = {1'b0, m[2:0]};
            ain1_raw_i = raw[k];
            ain2_raw_i = raw[k];
            step(4);
            note(3, {20'h0, m == 7 && k == 1, (m == 2 || m == 3) && k == 0, (m == 2 || m == 3) && k == 0,
               m == 7 && k == 1});
            note(4, m == 8 && k == 1);
            note(5, {lvl(m % 8, raw[k]), lvl(m, raw[k])});
         end
      end
      // Keypad keys: forward and reverse refused while disabled, all three honoured once enabled
      keypad_cfg_i = 1'b1;
      key_fwd_i = 1'b1;
      step(2);
      note(11, 24'h0);
      fwd_en_i = 1'b1;
      step(2);
      note(11, 24'h1);
      key_fwd_i = 1'b0;
      key_rev_i = 1'b1;
      step(2);
      note(11, 24'h1);
      rev_en_i = 1'b1;
      step(2);
      note(11, 24'h3);
      key_rev_i = 1'b0;
      stop_en_i = 1'b1;
      key_stop_i = 1'b1;
      step(2);
      key_stop_i = 1'b0;
      note(12, 24'h0);
      // Terminal run, keypad stop, refused restart until the run contact recycles
      keypad_cfg_i = 1'b0;
      cmd[0] = 1'b1;
      step(5);
      note(12, 24'h1);
      key_stop_i = 1'b1;
      step(2);
      key_stop_i = 1'b0;
      step(5);
      note(12, 24'h0);
      cmd[0] = 1'b0;
      step(5);
      cmd[0] = 1'b1;
      step(5);
      note(12, 24'h1);
      cmd[0] = 1'b0;
      // Eight presets picked by the three select pins
      preset8_cfg_i = 1'b1;
      preset_refs_i = {$urandom, $urandom, $urandom, $urandom};
      for (int s = 0; s < 8; s++) begin
         cmd[6:4] = s[2:0];
         step(5);
         note(8, {8'h0, preset_refs_i[16 * s +: 16]});
      end
      // Gains apply only on reclosing the enable pin; limits and sum clamp
      pid_cfg_i = 1'b1;
      {pid_kd_i, pid_ki_i, pid_kp_i} = 24'($urandom);
      cmd[3] = 1'b1;
      step(5);
      g = {pid_kd_i, pid_ki_i, pid_kp_i};
      note(9, g);
      pid_kp_i = ~pid_kp_i;
      step(5);
      note(9, g);
      cmd[3] = 1'b0;
      step(5);
      cmd[3] = 1'b1;
      step(5);
      note(9, {pid_kd_i, pid_ki_i, pid_kp_i});
      foreach (rw[k]) begin
         pid_raw_i = rw[k];
         main_ref_i = mr[k];
         step(3);
         note(10, {8'h0, ex[k]});
      end
      // Motorised pot: one-sided floor, one slew step, power-up policies, gating
      pot_cfg_i = 1'b1;
      keypad_cfg_i = 1'b1;
      keypad_ref_i = 16'sh0123;
      pu_preset_i = 16'sh0456;
      cmd[2] = 1'b1;
      step(25100);
      note(6, 24'h0);
      cmd[2:1] = 2'b01;
      for (i = 0; i < 25100 && pot_level_o !== 16'sh0001; i++) step(1);
      cmd[1] = 1'b0;
      step(6);
      note(6, 24'h1);
      note(7, 24'h1);
      pot_mode_i = 2'h1;
      pulse_power(2'h1, 16'h0123);
      note(6, 24'h1);
      pot_mode_i = 2'h0;
      pulse_power(2'h2, 16'h0456);
      note(6, 24'h0);
      pot_mode_i = 2'h2;
      cmd[1] = 1'b1;
      step(25100);
      note(6, 24'h0);
      pulse_power(2'h0, 16'h0000);
      end_sim();
   end
endmodule
`default_nettype wire
